// ### design/swk_defs.vh
/*
 * Constants for the sleep and wake-up sequencer: register offsets, field
 * positions, reset values, interrupt vector and oscillator start-up count.
 * Assumes inclusion by bare name from design files.
 */
`ifndef SWK_DEFS_VH
`define SWK_DEFS_VH

`define SWK_ADDR_W 4
`define SWK_OFF_CTRL 4'h0
`define SWK_OFF_STAT 4'h4
`define SWK_OFF_IRQ_STAT 4'h8
`define SWK_OFF_IRQ_MASK 4'hc

`define SWK_CTRL_OSC_LSB 0
`define SWK_CTRL_OSC_MSB 1
`define SWK_CTRL_RESET 8'h00

`define SWK_OSC_RC 2'h0
`define SWK_OSC_STD 2'h1
`define SWK_OSC_FAST 2'h2
`define SWK_OSC_LOWPOWER 2'h3

`define SWK_EV_SLEEP 0
`define SWK_EV_SKIP 1
`define SWK_EV_WAKE 2
`define SWK_EV_VECTOR 3
`define SWK_EV_W 4

`define SWK_IRQ_VECTOR 13'h0004
`define SWK_PC_W 13
`define SWK_OST_PERIODS 1024
`define SWK_OST_CLK_PER_PERIOD 1

`define SWK_ST_RUN 2'h0
`define SWK_ST_SLEEP 2'h1
`define SWK_ST_OST 2'h2
`define SWK_ST_RESUME 2'h3

`endif

// ### design/swk_sleep_wakeup.v
/*
 * Sleep and wake-up sequencer of the core: decides whether a sleep
 * instruction really sleeps, updates watchdog and status flags, applies the
 * oscillator start-up delay and vectors or resumes on wake-up.
 * Assumes the core presents one execute strobe per sleep instruction and
 * that all inputs except arst_n_i are synchronous to ref_clk_i.
 */
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "swk_defs.vh"
`default_nettype none

module swk_sleep_wakeup #(
    parameter N_SRC = 17,
    parameter OST_CYCLES = `SWK_OST_PERIODS * `SWK_OST_CLK_PER_PERIOD
) (
    // Clock and reset.
    input wire ref_clk_i,
    input wire arst_n_i,
    // Interrupt sources and core control.
    input wire [N_SRC-1:0] irq_enable_i,
    input wire [N_SRC-1:0] irq_flag_i,
    input wire global_irq_enable_i,
    input wire sleep_exec_i,
    input wire clrwdt_exec_i,
    input wire [`SWK_PC_W-1:0] pc_next_i,
    // Register port.
    input wire [`SWK_ADDR_W-1:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    // Core sequencing outputs.
    output reg asleep_o,
    output reg core_stall_o,
    output reg watchdog_counter_clr_o,
    output reg timeout_flag_n_o,
    output reg powerdown_flag_n_o,
    output reg global_irq_enable_clr_o,
    output reg stack_push_o,
    output reg [`SWK_PC_W-1:0] stack_push_addr_o,
    output reg pc_load_o,
    output reg [`SWK_PC_W-1:0] pc_load_addr_o,
    output reg irq_o
);

    localparam CNT_W = 16;
    localparam [CNT_W-1:0] OST_LOAD = OST_CYCLES - 1;
    localparam [CNT_W-1:0] CNT_ONE = 16'h0001;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [CNT_W-1:0] ost_cnt_reg;
    reg [CNT_W-1:0] ost_cnt_next;
    reg [1:0] osc_mode_reg;
    reg [`SWK_EV_W-1:0] irq_stat_reg;
    reg [`SWK_EV_W-1:0] irq_mask_reg;
    reg [`SWK_PC_W-1:0] ret_addr_reg;
    reg [`SWK_EV_W-1:0] ev_next;
    reg [`SWK_EV_W-1:0] irq_stat_next;
    wire [N_SRC-1:0] src_req;
    wire wake_req;
    wire sleep_go;
    wire crystal;

    function is_wr;
        input [`SWK_ADDR_W-1:0] off;
        begin
            is_wr = reg_wr_i && (reg_addr_i == off);
        end
    endfunction

    function [31:0] rd_word;
        input [`SWK_ADDR_W-1:0] off;
        begin
            case (off)
                `SWK_OFF_CTRL: rd_word = {30'h0, osc_mode_reg};
                `SWK_OFF_STAT: rd_word = {27'h0, state_reg, timeout_flag_n_o, powerdown_flag_n_o, asleep_o};
                `SWK_OFF_IRQ_STAT: rd_word = {28'h0, irq_stat_reg};
                `SWK_OFF_IRQ_MASK: rd_word = {28'h0, irq_mask_reg};
                default: rd_word = 32'h0000_0000;
            endcase
        end
    endfunction

    // Each source pairs its own enable and flag; the global enable plays no part here.
    genvar g;
    generate
        for (g = 0; g < N_SRC; g = g + 1) begin : g_src
            assign src_req[g] = irq_enable_i[g] & irq_flag_i[g];
        end
    endgenerate

    assign wake_req = |src_req;
    assign sleep_go = (state_reg == `SWK_ST_RUN) && sleep_exec_i && !wake_req;
    assign crystal = (osc_mode_reg != `SWK_OSC_RC);

    // Events are gathered combinationally so that set beats a clear in the same cycle.
    always @* begin
        ev_next = {`SWK_EV_W{1'b0}};
        if (state_reg == `SWK_ST_RUN && sleep_exec_i) begin
            ev_next[`SWK_EV_SLEEP] = !wake_req;
            ev_next[`SWK_EV_SKIP] = wake_req;
        end
        if (state_reg == `SWK_ST_SLEEP && wake_req) begin
            ev_next[`SWK_EV_WAKE] = 1'b1;
        end
        if (state_reg == `SWK_ST_RESUME && global_irq_enable_i) begin
            ev_next[`SWK_EV_VECTOR] = 1'b1;
        end
        irq_stat_next = irq_stat_reg;
        if (is_wr(`SWK_OFF_IRQ_STAT)) begin
            irq_stat_next = irq_stat_reg & ~reg_wdata_i[`SWK_EV_W-1:0];
        end
        irq_stat_next = irq_stat_next | ev_next;
    end

    always @* begin
        state_next = state_reg;
        ost_cnt_next = ost_cnt_reg;
        case (state_reg)
            `SWK_ST_RUN: begin
                if (sleep_go) begin
                    state_next = `SWK_ST_SLEEP;
                end
            end
            `SWK_ST_SLEEP: begin
                if (wake_req) begin
                    if (crystal) begin
                        ost_cnt_next = OST_LOAD;
                        state_next = `SWK_ST_OST;
                    end else begin
                        state_next = `SWK_ST_RESUME;
                    end
                end
            end
            `SWK_ST_OST: begin
                // The count is in reference clocks, one per oscillator period by default.
                if (ost_cnt_reg == {CNT_W{1'b0}}) begin
                    state_next = `SWK_ST_RESUME;
                end else begin
                    ost_cnt_next = ost_cnt_reg - CNT_ONE;
                end
            end
            `SWK_ST_RESUME: begin
                state_next = `SWK_ST_RUN;
            end
            default: begin
                state_next = `SWK_ST_RUN;
            end
        endcase
    end

    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= `SWK_ST_RUN;
            ost_cnt_reg <= {CNT_W{1'b0}};
        end else begin
            state_reg <= state_next;
            ost_cnt_reg <= ost_cnt_next;
        end
    end

    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            watchdog_counter_clr_o <= 1'b0;
            timeout_flag_n_o <= 1'b1;
            powerdown_flag_n_o <= 1'b1;
        end else begin
            watchdog_counter_clr_o <= 1'b0;
            if (clrwdt_exec_i) begin
                watchdog_counter_clr_o <= 1'b1;
                timeout_flag_n_o <= 1'b1;
                powerdown_flag_n_o <= 1'b1;
            end
            // A skipped sleep never reaches this branch, so without a clrwdt_exec_i both flags keep their values and the watchdog clear returns to 0.
            if (sleep_go) begin
                watchdog_counter_clr_o <= 1'b1;
                timeout_flag_n_o <= 1'b1;
                powerdown_flag_n_o <= 1'b0;
            end
        end
    end

    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ret_addr_reg <= {`SWK_PC_W{1'b0}};
            asleep_o <= 1'b0;
            core_stall_o <= 1'b0;
        end else begin
            if (state_reg == `SWK_ST_RUN && sleep_exec_i) begin
                ret_addr_reg <= pc_next_i;
            end
            // The sleep completes fully; a request after this edge wakes from the sleep state.
            if (sleep_go) begin
                asleep_o <= 1'b1;
                core_stall_o <= 1'b1;
            end
            if (state_reg == `SWK_ST_SLEEP && wake_req) begin
                asleep_o <= 1'b0;
            end
            if (state_reg == `SWK_ST_RESUME) begin
                core_stall_o <= 1'b0;
            end
        end
    end

    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            global_irq_enable_clr_o <= 1'b0;
            stack_push_o <= 1'b0;
            stack_push_addr_o <= {`SWK_PC_W{1'b0}};
            pc_load_o <= 1'b0;
            pc_load_addr_o <= {`SWK_PC_W{1'b0}};
        end else begin
            global_irq_enable_clr_o <= 1'b0;
            stack_push_o <= 1'b0;
            pc_load_o <= 1'b0;
            if (state_reg == `SWK_ST_RESUME && global_irq_enable_i) begin
                global_irq_enable_clr_o <= 1'b1;
                stack_push_o <= 1'b1;
                stack_push_addr_o <= ret_addr_reg;
                pc_load_o <= 1'b1;
                pc_load_addr_o <= `SWK_IRQ_VECTOR;
            end
        end
    end

    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            osc_mode_reg <= `SWK_OSC_RC;
            irq_mask_reg <= {`SWK_EV_W{1'b0}};
        end else begin
            if (is_wr(`SWK_OFF_CTRL)) begin
                osc_mode_reg <= reg_wdata_i[`SWK_CTRL_OSC_MSB:`SWK_CTRL_OSC_LSB];
            end
            if (is_wr(`SWK_OFF_IRQ_MASK)) begin
                irq_mask_reg <= reg_wdata_i[`SWK_EV_W-1:0];
            end
        end
    end

    // The interrupt line follows the mask one cycle late, which keeps it a plain register output.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_stat_reg <= {`SWK_EV_W{1'b0}};
            irq_o <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_o <= |(irq_stat_next & irq_mask_reg);
        end
    end

    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_word(reg_addr_i);
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

endmodule // swk_sleep_wakeup

`default_nettype wire

// ### tb/swk_sleep_wakeup_props.sv
/* Port checker for the sleep and wake-up sequencer.
   Assumes a bind from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module swk_props #(parameter N_SRC = 17, parameter OST_CYCLES = 8) (
    // Inputs.
    input wire ref_clk_i,
    input wire arst_n_i,
    input wire [N_SRC-1:0] irq_enable_i,
    input wire [N_SRC-1:0] irq_flag_i,
    input wire global_irq_enable_i,
    input wire sleep_exec_i,
    input wire clrwdt_exec_i,
    input wire reg_rd_i,
    // Outputs.
    input wire [31:0] reg_rdata_o,
    input wire asleep_o,
    input wire core_stall_o,
    input wire watchdog_counter_clr_o,
    input wire timeout_flag_n_o,
    input wire powerdown_flag_n_o,
    input wire global_irq_enable_clr_o,
    input wire pc_load_o,
    input wire [12:0] pc_load_addr_o
);
    localparam int OST_MAX = OST_CYCLES + 1;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    wire req = |(irq_enable_i & irq_flag_i);
    // A clear-watchdog in the same cycle would mask the flag checks.
    wire go = sleep_exec_i && !core_stall_o && !clrwdt_exec_i;
    property p_skip; go && req |=> !asleep_o && !watchdog_counter_clr_o
        && powerdown_flag_n_o == $past(powerdown_flag_n_o); endproperty
    a_skip: assert property (p_skip) else $error("skipped sleep changed state");
    property p_sleep; go && !req |=> asleep_o && core_stall_o && watchdog_counter_clr_o
        && timeout_flag_n_o && !powerdown_flag_n_o; endproperty
    a_sleep: assert property (p_sleep) else $error("real sleep entry wrong");
    property p_wake; asleep_o && req |=> !asleep_o; endproperty
    a_wake: assert property (p_wake) else $error("no wake on request");
    property p_ost; $fell(asleep_o) |-> core_stall_o ##[1:OST_MAX] !core_stall_o; endproperty
    a_ost: assert property (p_ost) else $error("start-up delay too long");
    property p_vec; $fell(core_stall_o) && global_irq_enable_i |-> pc_load_o && global_irq_enable_clr_o; endproperty
    a_vec: assert property (p_vec) else $error("no vector on wake");
    property p_inl; $fell(core_stall_o) && !global_irq_enable_i |-> !pc_load_o; endproperty
    a_inl: assert property (p_inl) else $error("vectored with global enable off");
    property p_addr; pc_load_o |-> pc_load_addr_o == 13'h0004; endproperty
    a_addr: assert property (p_addr) else $error("wrong vector address");
    property p_rd; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
    a_rd: assert property (p_rd) else $error("read data outside read slot");
    c_sleep: cover property (go && !req);
    c_skip: cover property (go && req);
    c_vec: cover property (pc_load_o);
endmodule // swk_props
`default_nettype wire

// ### tb/testbench.sv
/* Self-checking bench for the sleep and wake-up sequencer.
   Assumes the design header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "swk_defs.vh"
module testbench;
    localparam int OST = 8;
    logic ref_clk_i = 0, arst_n_i = 0, global_irq_enable_i = 0, sleep_exec_i = 0;
    logic clrwdt_exec_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic [16:0] irq_enable_i = 17'h1, irq_flag_i = 17'h0;
    logic [12:0] pc_next_i = 13'h0123;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    wire [31:0] reg_rdata_o;
    wire asleep_o, core_stall_o, watchdog_counter_clr_o, timeout_flag_n_o, powerdown_flag_n_o;
    wire global_irq_enable_clr_o, stack_push_o, pc_load_o, irq_o;
    wire [12:0] stack_push_addr_o, pc_load_addr_o;
    integer failures = 0, compares = 0, n, k;
    // Mode, global enable, stall cycles seen after the wake edge.
    int rows [0:4][0:2] = '{'{0, 1, 1}, '{1, 0, OST + 1}, '{2, 1, OST + 1}, '{3, 0, OST + 1}, '{0, 0, 1}};
    swk_sleep_wakeup #(.N_SRC(17), .OST_CYCLES(OST)) i_swk_sleep_wakeup (.ref_clk_i, .arst_n_i,
        .irq_enable_i, .irq_flag_i, .global_irq_enable_i, .sleep_exec_i, .clrwdt_exec_i, .pc_next_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .asleep_o, .core_stall_o,
        .watchdog_counter_clr_o, .timeout_flag_n_o, .powerdown_flag_n_o, .global_irq_enable_clr_o,
        .stack_push_o, .stack_push_addr_o, .pc_load_o, .pc_load_addr_o, .irq_o);
    always #2 ref_clk_i = ~ref_clk_i;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tick;
        @(posedge ref_clk_i);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1;
        @(posedge ref_clk_i);
        reg_wr_i <= 0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1;
        @(posedge ref_clk_i);
        reg_rd_i <= 0;
        #1 chk(reg_rdata_o, e);
    endtask
    task slp;
        @(posedge ref_clk_i);
        sleep_exec_i <= 1;
        @(posedge ref_clk_i);
        sleep_exec_i <= 0;
        #1;
    endtask
    task test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_i);
        arst_n_i <= 1;
        for (k = 0; k < 5; k++) begin
            wr(`SWK_OFF_CTRL, rows[k][0]);
            global_irq_enable_i <= rows[k][1];
            irq_flag_i <= 17'h2;
            slp();
            chk(asleep_o, 1);
            chk(powerdown_flag_n_o, 0);
            chk(watchdog_counter_clr_o, 1);
            chk(timeout_flag_n_o, 1);
            chk(core_stall_o, 1);
            repeat (3) @(posedge ref_clk_i);
            irq_flag_i <= 17'h3;
            chk(asleep_o, 1);
            tick();
            chk(asleep_o, 0);
            n = 0;
            while (core_stall_o === 1'b1 && n < 50) begin
                tick();
                n++;
            end
            chk(n, rows[k][2]);
            chk(pc_load_o, rows[k][1]);
            chk(global_irq_enable_clr_o, rows[k][1]);
            chk(stack_push_o, rows[k][1]);
            if (rows[k][1]) chk(stack_push_addr_o, 32'h123);
            if (rows[k][1]) chk(pc_load_addr_o, `SWK_IRQ_VECTOR);
            @(posedge ref_clk_i);
            irq_flag_i <= 17'h0;
            $display("row %0d done", k);
        end
        // A source other than the first shows the request is an OR of all pairs.
        @(posedge ref_clk_i);
        clrwdt_exec_i <= 1;
        @(posedge ref_clk_i);
        clrwdt_exec_i <= 0;
        irq_enable_i <= 17'h10000;
        irq_flag_i <= 17'h10000;
        wr(`SWK_OFF_IRQ_STAT, 32'hf);
        slp();
        chk(asleep_o, 0);
        chk(powerdown_flag_n_o, 1);
        chk(watchdog_counter_clr_o, 0);
        chk(timeout_flag_n_o, 1);
        chk(core_stall_o, 0);
        rd(`SWK_OFF_STAT, 32'h6);
        rd(`SWK_OFF_IRQ_STAT, 32'h2);
        chk(irq_o, 0);
        wr(`SWK_OFF_IRQ_MASK, 32'h2);
        tick();
        chk(irq_o, 1);
        wr(`SWK_OFF_IRQ_STAT, 32'h2);
        tick();
        chk(irq_o, 0);
        rd(4'h2, 32'h0);
        $display("skip and interrupt test done");
        wr(`SWK_OFF_CTRL, 32'h1);
        irq_flag_i <= 17'h0;
        slp();
        @(posedge ref_clk_i);
        arst_n_i <= 0;
        #1 chk(powerdown_flag_n_o, 1);
        chk(asleep_o, 0);
        @(posedge ref_clk_i);
        arst_n_i <= 1;
        rd(`SWK_OFF_CTRL, 32'h0);
        $display("reset test done");
        test_done();
    end
    initial begin
        #40000;
        failures++;
        test_done();
    end
endmodule // testbench
bind swk_sleep_wakeup swk_props #(.N_SRC(N_SRC), .OST_CYCLES(OST_CYCLES)) i_swk_props (.ref_clk_i, .arst_n_i,
    .irq_enable_i, .irq_flag_i, .global_irq_enable_i, .sleep_exec_i, .clrwdt_exec_i, .reg_rd_i, .reg_rdata_o,
    .asleep_o, .core_stall_o, .watchdog_counter_clr_o, .timeout_flag_n_o, .powerdown_flag_n_o,
    .global_irq_enable_clr_o, .pc_load_o, .pc_load_addr_o);
`default_nettype wire
